/* core/ocd_pkg.sv */
// package for the output channel clock divider: register indices,
// field positions, reset values and the packed carriers.
// assumes a 20 MHz ref_clk and an AXI4-Lite master with 32-bit data.
package ocd_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_PAIR_B_ROUTE = 10'h195;
  localparam logic [9:0] IDX_DIV_C_DUR    = 10'h196;
  localparam logic [9:0] IDX_DIV_C_CTL    = 10'h197;
  localparam logic [9:0] IDX_PAIR_C_ROUTE = 10'h198;
  localparam logic [9:0] IDX_SRC_SEL      = 10'h1E1;
  localparam logic [9:0] IDX_STATUS       = 10'h1F0;
  localparam logic [9:0] IDX_SYNC_CTL     = 10'h230;
  // reset values
  localparam logic [7:0] RST_PAIR_B_ROUTE = 8'h00;
  localparam logic [7:0] RST_DIV_C_DUR    = 8'h00;
  localparam logic [7:0] RST_DIV_C_CTL    = 8'h00;
  localparam logic [7:0] RST_PAIR_C_ROUTE = 8'h00;
  localparam logic [7:0] RST_SRC_SEL      = 8'h00;
  localparam logic [7:0] RST_SYNC_CTL     = 8'h00;
  // field positions in the route and sync registers
  localparam int unsigned BIT_DIRECT    = 1;
  localparam int unsigned BIT_DCC_OFF   = 0;
  localparam int unsigned BIT_SOFT_SYNC = 0;
  // source select codes
  localparam logic [1:0] SEL_EXT  = 2'h0;
  localparam logic [1:0] SEL_NONE = 2'h1;
  localparam logic [1:0] SEL_OSC  = 2'h2;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // duration register layout
  typedef struct packed {
    logic [3:0] low;
    logic [3:0] high;
  } ocd_dur_t;
  // divider control register layout
  typedef struct packed {
    logic       bypass;
    logic       nosync;
    logic       force_hi;
    logic       start_hi;
    logic [3:0] phase;
  } ocd_ctl_t;
endpackage

/* core/ocd_divider.sv */
// third output channel divider with routing of both output pairs,
// behind an AXI4-Lite register slave.
// assumes source clocks far slower than ref_clk; they are sampled.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/10ps

// Notes on behaviour
// - low phase lasts low field plus one
// - high phase lasts high field plus one
// - bypass passes divider input straight through
// - sync-ignore bit makes divider disregard sync
// - sync-ignore holds output at force level
// - force level has no effect under bypass
// - start polarity sets first output level
// - four-bit phase offset, reset zero
// - routing bit clear: pair fed by divider
// - routing with select 10 sends oscillator
// - routing with select 00 sends external clock
// - select 01 makes routing bit do nothing
// - correction-disable bit turns duty correction off
// - second pair uses same routing scheme
// - durations reset to zero, divider in use
// - select bit one picks oscillator over external
// - sync holds divider c, release restarts it
module ocd_divider (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        internal_oscillator,
  input  wire logic        ext_clk_in,
  input  wire logic        sync_n,
  input  wire logic        div_b_clk,
  output logic             pair_b_first_output,
  output logic             pair_b_second_output,
  output logic             pair_c_first_output,
  output logic             pair_c_second_output,
  output logic             pair_b_duty_correct_en,
  output logic             pair_c_duty_correct_en
);

  // software registers
  logic [7:0] pair_b_route_q;         // routing and duty, pair b
  logic [7:0] pair_c_route_q;         // routing and duty, pair c
  logic [7:0] src_sel_q;              // source select
  logic [7:0] sync_ctl_q;             // soft sync
  ocd_pkg::ocd_dur_t divider_c_durations_q;
  ocd_pkg::ocd_ctl_t divider_c_control_phase_q;

  // pin synchronisers, two flops each; third flop only for edges
  logic [1:0] osc_s_q;                // oscillator pin
  logic [1:0] ext_s_q;                // external clock pin
  logic [1:0] sync_s_q;               // sync pin, active low
  logic       src_prev_q;             // last selected source level
  // selected divider input, declared here since the edge flop reads it
  wire [1:0] sel      = src_sel_q[1:0];
  wire       src_lvl  = sel[1] ? osc_s_q[1] : ext_s_q[1];
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      osc_s_q    <= 2'h0;
      ext_s_q    <= 2'h0;
      sync_s_q   <= 2'h3;
      src_prev_q <= 1'b0;
    end else begin
      osc_s_q    <= {osc_s_q[0], internal_oscillator};
      ext_s_q    <= {ext_s_q[0], ext_clk_in};
      sync_s_q   <= {sync_s_q[0], sync_n};
      src_prev_q <= src_lvl;
    end
  end

  // edge detect and sync decode
  wire       src_tick = src_lvl & ~src_prev_q;            // rising input edge
  wire       sync_act = ~sync_s_q[1] | sync_ctl_q[ocd_pkg::BIT_SOFT_SYNC];
  wire       c_bypass = divider_c_control_phase_q.bypass;
  wire       c_nosync = divider_c_control_phase_q.nosync;
  // sync obeyed only without nosync; bypass also holds the counter
  wire       hold     = (sync_act & ~c_nosync) | c_bypass;
  // a select of 01 leaves routing bits without effect
  wire       sel_ok   = (sel != ocd_pkg::SEL_NONE);

  // divider state
  logic       lvl_q;                  // divided level
  logic [4:0] cnt_q;                  // input cycles left in phase
  wire  [3:0] dur_hi = divider_c_durations_q.high;
  wire  [3:0] dur_lo = divider_c_durations_q.low;
  wire        st_hi  = divider_c_control_phase_q.start_hi;
  // restart value: first phase plus the coarse phase offset
  wire  [4:0] ld_start = {1'b0, st_hi ? dur_hi : dur_lo}
                       + {1'b0, divider_c_control_phase_q.phase};
  // each new phase counts field down to zero: field plus one inputs
  wire  [4:0] ld_next  = {1'b0, lvl_q ? dur_lo : dur_hi};

  // divider counter; period is the sum of both phases
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lvl_q <= 1'b0;
      cnt_q <= 5'h00;
    end else if (hold) begin
      lvl_q <= st_hi;
      cnt_q <= ld_start;
    end else if (src_tick) begin
      if (cnt_q == 5'h00) begin
        lvl_q <= ~lvl_q;
        cnt_q <= ld_next;
      end else begin
        cnt_q <= cnt_q - 5'h01;
      end
    end
  end

  // divider output: bypass beats force, nosync freezes at force level
  wire div_c_out = c_bypass ? src_lvl
                 : c_nosync ? divider_c_control_phase_q.force_hi
                 : lvl_q;
  wire c_direct  = pair_c_route_q[ocd_pkg::BIT_DIRECT] & sel_ok;
  wire b_direct  = pair_b_route_q[ocd_pkg::BIT_DIRECT] & sel_ok;
  wire pair_c_d  = c_direct ? src_lvl : div_c_out;
  wire pair_b_d  = b_direct ? src_lvl : div_b_clk;

  // output flops; correction enables are the inverted disable bits
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pair_b_first_output    <= 1'b0;
      pair_b_second_output   <= 1'b0;
      pair_c_first_output    <= 1'b0;
      pair_c_second_output   <= 1'b0;
      pair_b_duty_correct_en <= 1'b1;
      pair_c_duty_correct_en <= 1'b1;
    end else begin
      pair_b_first_output    <= pair_b_d;
      pair_b_second_output   <= pair_b_d;
      pair_c_first_output    <= pair_c_d;
      pair_c_second_output   <= pair_c_d;
      pair_b_duty_correct_en <= ~pair_b_route_q[ocd_pkg::BIT_DCC_OFF];
      pair_c_duty_correct_en <= ~pair_c_route_q[ocd_pkg::BIT_DCC_OFF];
    end
  end

  // write channel: address and data taken in either order
  logic        aw_got_q;              // address held
  logic        w_got_q;               // data held
  logic [9:0]  aw_idx_q;              // held word index
  logic [7:0]  w_byte_q;              // held low byte
  logic        w_strb_q;              // held lane 0 strobe
  wire         aw_take = s_axi_awvalid & s_axi_awready;
  wire         w_take  = s_axi_wvalid & s_axi_wready;
  wire         have_a  = aw_got_q | aw_take;
  wire         have_w  = w_got_q | w_take;
  wire         wr_do   = have_a & have_w;
  wire         b_d     = wr_do | (s_axi_bvalid & ~s_axi_bready);
  wire [9:0]   wr_idx  = aw_got_q ? aw_idx_q : s_axi_awaddr[11:2];
  wire [7:0]   wr_byte = w_got_q ? w_byte_q : s_axi_wdata[7:0];
  wire         wr_strb = w_got_q ? w_strb_q : s_axi_wstrb[0];
  wire         wr_en   = wr_do & wr_strb;
  wire         wr_hit  = (wr_idx == ocd_pkg::IDX_PAIR_B_ROUTE)
                       | (wr_idx == ocd_pkg::IDX_DIV_C_DUR)
                       | (wr_idx == ocd_pkg::IDX_DIV_C_CTL)
                       | (wr_idx == ocd_pkg::IDX_PAIR_C_ROUTE)
                       | (wr_idx == ocd_pkg::IDX_SRC_SEL)
                       | (wr_idx == ocd_pkg::IDX_SYNC_CTL);

  // write handshake flops; each ready drops while its own channel is held or a response is pending
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      aw_idx_q      <= 10'h000;
      w_byte_q      <= 8'h00;
      w_strb_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= ocd_pkg::RESP_OKAY;
    end else begin
      aw_got_q      <= have_a & ~wr_do;
      w_got_q       <= have_w & ~wr_do;
      if (aw_take) aw_idx_q <= s_axi_awaddr[11:2];
      if (w_take) begin
        w_byte_q <= s_axi_wdata[7:0];
        w_strb_q <= s_axi_wstrb[0];
      end
      s_axi_awready <= ~(have_a & ~wr_do) & ~b_d;
      s_axi_wready  <= ~(have_w & ~wr_do) & ~b_d;
      s_axi_bvalid  <= b_d;
      // unmapped writes answer slave error and change nothing
      if (wr_do) s_axi_bresp <= wr_hit ? ocd_pkg::RESP_OKAY : ocd_pkg::RESP_SLVERR;
    end
  end

  // register file; reset leaves the divider in use, shortest phases
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pair_b_route_q            <= ocd_pkg::RST_PAIR_B_ROUTE;
      pair_c_route_q            <= ocd_pkg::RST_PAIR_C_ROUTE;
      divider_c_durations_q     <= ocd_pkg::RST_DIV_C_DUR;
      divider_c_control_phase_q <= ocd_pkg::RST_DIV_C_CTL;
      src_sel_q                 <= ocd_pkg::RST_SRC_SEL;
      sync_ctl_q                <= ocd_pkg::RST_SYNC_CTL;
    end else if (wr_en) begin
      if (wr_idx == ocd_pkg::IDX_PAIR_B_ROUTE) pair_b_route_q <= wr_byte;
      if (wr_idx == ocd_pkg::IDX_PAIR_C_ROUTE) pair_c_route_q <= wr_byte;
      if (wr_idx == ocd_pkg::IDX_DIV_C_DUR) divider_c_durations_q <= wr_byte;
      if (wr_idx == ocd_pkg::IDX_DIV_C_CTL) divider_c_control_phase_q <= wr_byte;
      if (wr_idx == ocd_pkg::IDX_SRC_SEL) src_sel_q <= wr_byte;
      if (wr_idx == ocd_pkg::IDX_SYNC_CTL) sync_ctl_q <= wr_byte;
    end
  end

  // read channel: one read at a time, answered the cycle after it is taken
  wire        ar_take = s_axi_arvalid & s_axi_arready;
  wire        r_d     = ar_take | (s_axi_rvalid & ~s_axi_rready);
  wire [9:0]  rd_idx  = s_axi_araddr[11:2];
  wire [7:0]  status  = {4'h0, pair_b_d, pair_c_d, hold, lvl_q};
  wire        rd_hit  = (rd_idx == ocd_pkg::IDX_PAIR_B_ROUTE)
                      | (rd_idx == ocd_pkg::IDX_DIV_C_DUR)
                      | (rd_idx == ocd_pkg::IDX_DIV_C_CTL)
                      | (rd_idx == ocd_pkg::IDX_PAIR_C_ROUTE)
                      | (rd_idx == ocd_pkg::IDX_SRC_SEL)
                      | (rd_idx == ocd_pkg::IDX_STATUS)
                      | (rd_idx == ocd_pkg::IDX_SYNC_CTL);
  wire [7:0]  rd_mux  =
      (rd_idx == ocd_pkg::IDX_PAIR_B_ROUTE) ? pair_b_route_q
    : (rd_idx == ocd_pkg::IDX_DIV_C_DUR)    ? divider_c_durations_q
    : (rd_idx == ocd_pkg::IDX_DIV_C_CTL)    ? divider_c_control_phase_q
    : (rd_idx == ocd_pkg::IDX_PAIR_C_ROUTE) ? pair_c_route_q
    : (rd_idx == ocd_pkg::IDX_SRC_SEL)      ? src_sel_q
    : (rd_idx == ocd_pkg::IDX_STATUS)       ? status
    : (rd_idx == ocd_pkg::IDX_SYNC_CTL)     ? sync_ctl_q
    : 8'h00;

  // read handshake flops; unmapped reads return zero with slave error
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= ocd_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= ~r_d;
      s_axi_rvalid  <= r_d;
      if (ar_take) begin
        s_axi_rdata <= {24'h000000, rd_mux};
        s_axi_rresp <= rd_hit ? ocd_pkg::RESP_OKAY : ocd_pkg::RESP_SLVERR;
      end
    end
  end

  // helper: input ticks seen in the current phase, for the checks below
  logic [4:0] ph_ticks_q;             // ticks since last toggle
  logic       first_q;                // first phase after restart
  logic       dur_wr_q;               // durations rewritten during this phase
  wire        toggle = ~hold & src_tick & (cnt_q == 5'h00);
  wire        dur_wr = wr_en & (wr_idx == ocd_pkg::IDX_DIV_C_DUR);
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ph_ticks_q <= 5'h00;
      first_q    <= 1'b1;
      dur_wr_q   <= 1'b0;
    end else begin
      // a write in the toggling cycle still marks the phase that follows
      dur_wr_q <= dur_wr | (dur_wr_q & ~(hold | toggle));
      if (hold | toggle) begin
        ph_ticks_q <= 5'h00;
        first_q    <= hold;
      end else if (src_tick) begin
        ph_ticks_q <= ph_ticks_q + 5'h01;
      end
    end
  end

  // apart from the first phase after restart and phases with rewritten durations, a phase ends after exactly its field plus one input edges
  property p_low_len;
    @(posedge ref_clk) disable iff (!arst_n)
      (toggle && !lvl_q && !first_q && !dur_wr_q) |-> ph_ticks_q == {1'b0, dur_lo};
  endproperty
  a_low_len: assert property (p_low_len) else $error("low phase length wrong");

  property p_high_len;
    @(posedge ref_clk) disable iff (!arst_n)
      (toggle && lvl_q && !first_q && !dur_wr_q) |-> ph_ticks_q == {1'b0, dur_hi};
  endproperty
  a_high_len: assert property (p_high_len) else $error("high phase length wrong");

  property p_bypass;
    @(posedge ref_clk) disable iff (!arst_n)
      (c_bypass && !c_direct) |=> pair_c_first_output == $past(src_lvl);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass did not pass input");

  property p_force;
    @(posedge ref_clk) disable iff (!arst_n)
      (!c_bypass && c_nosync && !c_direct)
        |=> pair_c_second_output == $past(divider_c_control_phase_q.force_hi);
  endproperty
  a_force: assert property (p_force) else $error("force level not held");

  // release of a held divider restarts it at start level
  sequence s_release;
    hold ##1 !hold;
  endsequence
  property p_restart;
    @(posedge ref_clk) disable iff (!arst_n)
      s_release |-> lvl_q == $past(st_hi) && first_q;
  endproperty
  a_restart: assert property (p_restart) else $error("restart level wrong");

  property p_route_osc;
    @(posedge ref_clk) disable iff (!arst_n)
      (pair_c_route_q[1] && sel == ocd_pkg::SEL_OSC)
        |=> pair_c_first_output == $past(osc_s_q[1]);
  endproperty
  a_route_osc: assert property (p_route_osc) else $error("oscillator not routed");

  property p_route_ext;
    @(posedge ref_clk) disable iff (!arst_n)
      (pair_b_route_q[1] && sel == ocd_pkg::SEL_EXT)
        |=> pair_b_second_output == $past(ext_s_q[1]);
  endproperty
  a_route_ext: assert property (p_route_ext) else $error("external not routed");

  property p_route_none;
    @(posedge ref_clk) disable iff (!arst_n)
      (sel == ocd_pkg::SEL_NONE) |=> pair_c_first_output == $past(div_c_out)
        && pair_b_first_output == $past(div_b_clk);
  endproperty
  a_route_none: assert property (p_route_none) else $error("select 01 rerouted");

  property p_dcc;
    @(posedge ref_clk) disable iff (!arst_n)
      ##1 pair_c_duty_correct_en != $past(pair_c_route_q[0]);
  endproperty
  a_dcc: assert property (p_dcc) else $error("duty correction wrong");

endmodule

/* tb/ocd_src_model.sv */
// clock sources seen by the divider: oscillator, external clock and
// the second divider output, all far slower than ref_clk.
// assumes ref_clk runs free; each source toggles after a fixed count.
`timescale 1ns/10ps
module ocd_src_model #(
  parameter int EXT_HALF  = 4,   // ref_clk cycles per external half period
  parameter int OSC_HALF  = 6,   // ref_clk cycles per oscillator half period
  parameter int DIVB_HALF = 10   // ref_clk cycles per second divider half period
) (
  input  wire logic ref_clk,
  input  wire logic arst_n,
  output logic      internal_oscillator,
  output logic      ext_clk_in,
  output logic      div_b_clk
);
  logic [3:0] e_q, o_q, d_q;  // half period counters
  // distinct half periods let the bench tell each source by its shape
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      {e_q, o_q, d_q} <= 12'h000;
      {internal_oscillator, ext_clk_in, div_b_clk} <= 3'h0;
    end else begin
      e_q <= (e_q == 4'(EXT_HALF - 1)) ? 4'h0 : e_q + 4'h1;
      o_q <= (o_q == 4'(OSC_HALF - 1)) ? 4'h0 : o_q + 4'h1;
      d_q <= (d_q == 4'(DIVB_HALF - 1)) ? 4'h0 : d_q + 4'h1;
      if (e_q == 4'(EXT_HALF - 1)) ext_clk_in <= ~ext_clk_in;
      if (o_q == 4'(OSC_HALF - 1)) internal_oscillator <= ~internal_oscillator;
      if (d_q == 4'(DIVB_HALF - 1)) div_b_clk <= ~div_b_clk;
    end
  end
endmodule

/* tb/ocd_divider_test.sv */
// self-checking bench for the output channel divider: registers over
// AXI4-Lite, shapes of both pairs measured in ref_clk cycles.
// assumes sources from ocd_src_model: ext 4/4, osc 6/6, div_b 10/10.
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; \
  $display("[FAIL] %0t got %0h want %0h", $time, a, b); end end
module ocd_divider_test;
  logic        ref_clk = 1'b0;                  // 20 MHz clock
  logic        arst_n = 1'b0;                   // async reset, low active
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;              // low byte always enabled
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sync_n = 1'b1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        internal_oscillator, ext_clk_in, div_b_clk;
  logic        pair_b_first_output, pair_b_second_output;
  logic        pair_c_first_output, pair_c_second_output;
  logic        pair_b_duty_correct_en, pair_c_duty_correct_en;
  int          fail_count = 0;                  // mismatches
  int          samples_checked = 0;             // comparisons made

  always #25 ref_clk = ~ref_clk;

  ocd_divider i_ocd_divider (.ref_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .internal_oscillator, .ext_clk_in, .sync_n, .div_b_clk, .pair_b_first_output,
    .pair_b_second_output, .pair_c_first_output, .pair_c_second_output,
    .pair_b_duty_correct_en, .pair_c_duty_correct_en);
  ocd_src_model i_ocd_src_model (.ref_clk, .arst_n, .internal_oscillator,
    .ext_clk_in, .div_b_clk);

  // register write; aw and w offered together, each dropped once taken
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge ref_clk);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!(aw && w)) begin
      @(posedge ref_clk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
    `CHK(s_axi_bresp, ocd_pkg::RESP_OKAY)
    s_axi_bready <= 1'b0;
  endtask

  // register read, compared against the expected low byte and response
  task automatic rd(input logic [9:0] idx, input logic [7:0] e, input logic [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= {idx, 2'h0};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
    `CHK(s_axi_rdata, {24'h0, e})
    `CHK(s_axi_rresp, r)
    s_axi_rready <= 1'b0;
  endtask

  // first output of pair b (0) or pair c (1)
  function automatic logic lvl(input int ch);
    return ch ? pair_c_first_output : pair_b_first_output;
  endfunction

  // cycles until the chosen output reaches v; the watchdog bounds it
  task automatic wait_for(input int ch, input logic v, output int n);
    n = 0;
    while (lvl(ch) !== v) begin
      @(posedge ref_clk);
      n++;
    end
  endtask

  // skips one period so a restart or phase offset cannot skew it
  task automatic measure(input int ch, input int eh, input int el);
    int n, h, l;
    wait_for(ch, 1'b1, n);
    wait_for(ch, 1'b0, n);
    wait_for(ch, 1'b1, n);
    wait_for(ch, 1'b0, h);
    wait_for(ch, 1'b1, l);
    `CHK(h, eh)
    `CHK(l, el)
    `CHK(pair_b_first_output, pair_b_second_output)
    `CHK(pair_c_first_output, pair_c_second_output)
  endtask

  // output must sit at v for 40 cycles once settled
  task automatic steady(input int ch, input logic v);
    repeat (8) @(posedge ref_clk);
    repeat (40) begin
      @(posedge ref_clk);
      `CHK(lvl(ch), v)
    end
  endtask

  // reset values, unmapped access, shortest phases from reset
  task automatic t_reset();
    rd(ocd_pkg::IDX_DIV_C_DUR, 8'h00, ocd_pkg::RESP_OKAY);
    rd(ocd_pkg::IDX_DIV_C_CTL, 8'h00, ocd_pkg::RESP_OKAY);
    rd(ocd_pkg::IDX_PAIR_B_ROUTE, 8'h00, ocd_pkg::RESP_OKAY);
    rd(ocd_pkg::IDX_PAIR_C_ROUTE, 8'h00, ocd_pkg::RESP_OKAY);
    rd(10'h010, 8'h00, ocd_pkg::RESP_SLVERR);
    `CHK(pair_c_duty_correct_en, 1'b1)
    measure(1, 8, 8);
  endtask

  // durations: each phase is field plus one external periods
  task automatic t_ratio();
    wr(ocd_pkg::IDX_DIV_C_DUR, 8'h21);
    rd(ocd_pkg::IDX_DIV_C_DUR, 8'h21, ocd_pkg::RESP_OKAY);
    measure(1, 16, 24);
    wr(ocd_pkg::IDX_DIV_C_DUR, 8'hF0);
    measure(1, 8, 128);
    wr(ocd_pkg::IDX_DIV_C_DUR, 8'h21);
  endtask

  // pin and soft sync hold, nosync and force level, restart on release
  task automatic t_sync();
    int n;
    sync_n <= 1'b0;
    steady(1, 1'b0);
    wr(ocd_pkg::IDX_DIV_C_CTL, 8'h10);
    steady(1, 1'b1);
    wr(ocd_pkg::IDX_DIV_C_CTL, 8'h60);
    steady(1, 1'b1);
    wr(ocd_pkg::IDX_DIV_C_CTL, 8'h40);
    steady(1, 1'b0);
    wr(ocd_pkg::IDX_DIV_C_CTL, 8'h03);
    rd(ocd_pkg::IDX_DIV_C_CTL, 8'h03, ocd_pkg::RESP_OKAY);
    sync_n <= 1'b1;
    // first low phase is low field plus offset plus one: six ext periods
    wait_for(1, 1'b1, n);
    `CHK((n >= 40) && (n <= 56), 1'b1)
    measure(1, 16, 24);
    wr(ocd_pkg::IDX_SYNC_CTL, 8'h01);
    steady(1, 1'b0);
    wr(ocd_pkg::IDX_SYNC_CTL, 8'h00);
    measure(1, 16, 24);
  endtask

  // bypass passes the selected source, force level has no say
  task automatic t_bypass();
    wr(ocd_pkg::IDX_DIV_C_CTL, 8'hE0);
    measure(1, 4, 4);
    wr(ocd_pkg::IDX_SRC_SEL, 8'h02);
    wr(ocd_pkg::IDX_DIV_C_CTL, 8'h80);
    measure(1, 6, 6);
    wr(ocd_pkg::IDX_SRC_SEL, 8'h00);
    wr(ocd_pkg::IDX_DIV_C_CTL, 8'h00);
  endtask

  // direct routing of both pairs for select codes 00, 10 and 01
  task automatic t_route();
    measure(0, 10, 10);
    wr(ocd_pkg::IDX_PAIR_C_ROUTE, 8'h02);
    wr(ocd_pkg::IDX_PAIR_B_ROUTE, 8'h02);
    measure(1, 4, 4);
    measure(0, 4, 4);
    wr(ocd_pkg::IDX_SRC_SEL, 8'h02);
    measure(1, 6, 6);
    measure(0, 6, 6);
    wr(ocd_pkg::IDX_SRC_SEL, 8'h01);
    measure(1, 16, 24);
    measure(0, 10, 10);
  endtask

  // correction-disable bit drives each pair's enable low
  task automatic t_duty();
    wr(ocd_pkg::IDX_PAIR_C_ROUTE, 8'h01);
    repeat (3) @(posedge ref_clk);
    `CHK(pair_c_duty_correct_en, 1'b0)
    `CHK(pair_b_duty_correct_en, 1'b1)
    wr(ocd_pkg::IDX_PAIR_B_ROUTE, 8'h01);
    repeat (3) @(posedge ref_clk);
    `CHK(pair_b_duty_correct_en, 1'b0)
  endtask

  // counts then verdict; the one place the run ends
  task automatic results();
    $display("checked %0d, failed %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // a hung handshake or a dead output is cut short here
  initial begin
    repeat (40000) @(posedge ref_clk);
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    results();
  end

  initial begin
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_reset();
    t_ratio();
    t_sync();
    t_bypass();
    t_route();
    t_duty();
    results();
  end
endmodule
